// File: design/lcd_contrast_pkg.sv
// constants shared by the contrast generator and its register bank
package lcd_contrast_pkg;
  // register byte addresses
  localparam logic [31:0] contrast_control_addr = 32'h0060_0840;
  localparam logic [31:0] contrast_compare_addr = 32'h0060_0844;
  localparam logic [31:0] irq_enable_set_addr = 32'h0060_0848;
  localparam logic [31:0] irq_enable_clear_addr = 32'h0060_084c;
  localparam logic [31:0] irq_enable_view_addr = 32'h0060_0850;
  localparam logic [31:0] irq_pending_addr = 32'h0060_0854;
  localparam logic [31:0] irq_acknowledge_addr = 32'h0060_0858;
  // contrast_control fields
  localparam int prescale_select_lsb = 0;
  localparam int pulse_level_select_bit = 2;
  localparam int contrast_run_bit = 3;
  // event bit positions, common to all interrupt registers
  localparam int each_line_bit = 0;
  localparam int final_line_bit = 1;
  localparam int frame_done_bit = 2;
  localparam int fifo_empty_bit = 4;
  localparam int fifo_overrun_bit = 5;
  localparam int dma_fault_bit = 6;
  localparam int irq_width = 7;
  localparam logic [6:0] irq_valid_bits = 7'h77;
  // reset values
  localparam logic [3:0] contrast_control_reset = 4'h0;
  localparam logic [7:0] compare_level_reset = 8'h00;
  localparam logic [6:0] irq_reset = 7'h00;
  // prescaler encodings
  localparam logic [1:0] prescale_div1 = 2'h0;
  localparam logic [1:0] prescale_div2 = 2'h1;
  localparam logic [1:0] prescale_div4 = 2'h2;
  localparam logic [1:0] prescale_div8 = 2'h3;
  localparam logic [2:0] prescale_count_reset = 3'h0;
  // axi response codes
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// File: design/contrast_cfg_if.sv
// settings and output between the register bank and the pulse generator
`timescale 1ns/1ps
`default_nettype none
interface contrast_cfg_if;
  logic [1:0] prescale_select;
  logic pulse_level_select;
  logic contrast_run;
  logic [7:0] compare_level;
  logic contrast_out;
  logic [7:0] counter_value;
  modport regs (output prescale_select, pulse_level_select, contrast_run, compare_level,
    input contrast_out, counter_value);
  modport gen (input prescale_select, pulse_level_select, contrast_run, compare_level,
    output contrast_out, counter_value);
endinterface
`default_nettype wire

// File: design/contrast_pwm.sv
// prescaled eight-bit contrast pulse generator
`timescale 1ns/1ps
`default_nettype none
module contrast_pwm (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings and output
  contrast_cfg_if.gen cfg
);
  logic [2:0] presc_q;
  logic [2:0] presc_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic out_q;
  logic out_d;
  logic [2:0] presc_last;
  logic tick;
  logic below;

  assign presc_last = (cfg.prescale_select == lcd_contrast_pkg::prescale_div1) ? 3'h0 :
                      (cfg.prescale_select == lcd_contrast_pkg::prescale_div2) ? 3'h1 :
                      (cfg.prescale_select == lcd_contrast_pkg::prescale_div4) ? 3'h3 : 3'h7;
  assign tick = cfg.contrast_run && (presc_q >= presc_last);
  // a shrinking divide restarts the prescaler instead of waiting for a long wrap
  assign presc_d = !cfg.contrast_run || tick ? lcd_contrast_pkg::prescale_count_reset
                 : presc_q + 3'h1;
  assign count_d = tick ? count_q + 8'h01 : count_q;
  assign below = count_q < cfg.compare_level;
  // stopped counter freezes, but the output still follows compare_level and pulse_level_select against the frozen count
  assign out_d = cfg.pulse_level_select ? below : !below;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= lcd_contrast_pkg::prescale_count_reset;
      count_q <= 8'h00;
      out_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      count_q <= count_d;
      out_q <= out_d;
    end
  end

  assign cfg.contrast_out = out_q;
  assign cfg.counter_value = count_q;
endmodule
`default_nettype wire

// File: design/lcd_contrast_pwm_irq_regs.sv
// contrast pulse generator and interrupt registers behind an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module lcd_contrast_pwm_irq_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // one-cycle event pulses from the display engine, same clock
  input wire logic each_line_evt,
  input wire logic final_line_evt,
  input wire logic frame_done_evt,
  input wire logic fifo_empty_evt,
  input wire logic fifo_overrun_evt,
  input wire logic dma_fault_evt,
  // outputs
  output logic contrast_out,
  output logic irq
);
  contrast_cfg_if cfg ();

  logic [31:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [3:0] ctrl_q;
  logic [3:0] ctrl_d;
  logic [7:0] cmp_q;
  logic [7:0] cmp_d;
  logic [6:0] mask_q;
  logic [6:0] mask_d;
  logic [6:0] pend_q;
  logic [6:0] pend_d;
  logic irq_q;

  // write channel: address and data each caught independently
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire [31:0] wr_addr = {awaddr_q[31:2], 2'b00};
  wire [31:0] wr_data = wdata_q;

  wire wr_ctrl = wr_fire && (wr_addr == lcd_contrast_pkg::contrast_control_addr);
  wire wr_cmp = wr_fire && (wr_addr == lcd_contrast_pkg::contrast_compare_addr);
  wire wr_ien = wr_fire && (wr_addr == lcd_contrast_pkg::irq_enable_set_addr);
  wire wr_idis = wr_fire && (wr_addr == lcd_contrast_pkg::irq_enable_clear_addr);
  wire wr_view = wr_fire && (wr_addr == lcd_contrast_pkg::irq_enable_view_addr);
  wire wr_pend = wr_fire && (wr_addr == lcd_contrast_pkg::irq_pending_addr);
  wire wr_ack = wr_fire && (wr_addr == lcd_contrast_pkg::irq_acknowledge_addr);
  // writes to read-only registers are answered okay and ignored
  wire wr_hit = wr_ctrl || wr_cmp || wr_ien || wr_idis || wr_view || wr_pend || wr_ack;

  // all fields sit in byte lane 0, so only that strobe matters
  wire lane0 = wstrb_q[0];
  wire [6:0] wbits = wr_data[6:0] & lcd_contrast_pkg::irq_valid_bits;

  assign ctrl_d = (wr_ctrl && lane0) ? wr_data[3:0] : ctrl_q;
  assign cmp_d = (wr_cmp && lane0) ? wr_data[7:0] : cmp_q;
  assign mask_d = (mask_q | ((wr_ien && lane0) ? wbits : 7'h00))
                & ~((wr_idis && lane0) ? wbits : 7'h00);

  // read channel
  wire ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_q;
  wire [31:0] rd_addr = {s_axi_araddr[31:2], 2'b00};
  wire rd_ctrl = rd_addr == lcd_contrast_pkg::contrast_control_addr;
  wire rd_cmp = rd_addr == lcd_contrast_pkg::contrast_compare_addr;
  wire rd_view = rd_addr == lcd_contrast_pkg::irq_enable_view_addr;
  wire rd_pend = rd_addr == lcd_contrast_pkg::irq_pending_addr;
  wire rd_wo = rd_addr == lcd_contrast_pkg::irq_enable_set_addr
            || rd_addr == lcd_contrast_pkg::irq_enable_clear_addr
            || rd_addr == lcd_contrast_pkg::irq_acknowledge_addr;
  wire rd_hit = rd_ctrl || rd_cmp || rd_view || rd_pend || rd_wo;
  wire [31:0] rd_value = rd_ctrl ? {28'h000_0000, ctrl_q}
                       : rd_cmp ? {24'h00_0000, cmp_q}
                       : rd_view ? {25'h000_0000, mask_q}
                       : rd_pend ? {25'h000_0000, pend_q}
                       : 32'h0000_0000;

  // events latch; a read of the pending register also clears it, but a new event wins
  wire [6:0] evt_vec;
  assign evt_vec[lcd_contrast_pkg::each_line_bit] = each_line_evt;
  assign evt_vec[lcd_contrast_pkg::final_line_bit] = final_line_evt;
  assign evt_vec[lcd_contrast_pkg::frame_done_bit] = frame_done_evt;
  assign evt_vec[3] = 1'b0;
  assign evt_vec[lcd_contrast_pkg::fifo_empty_bit] = fifo_empty_evt;
  assign evt_vec[lcd_contrast_pkg::fifo_overrun_bit] = fifo_overrun_evt;
  assign evt_vec[lcd_contrast_pkg::dma_fault_bit] = dma_fault_evt;
  wire [6:0] ack_bits = (wr_ack && lane0) ? wbits : 7'h00;
  wire [6:0] rd_clr = (ar_take && rd_pend) ? 7'h7f : 7'h00;
  assign pend_d = (pend_q & ~ack_bits & ~rd_clr) | evt_vec;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= lcd_contrast_pkg::resp_okay;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? lcd_contrast_pkg::resp_okay : lcd_contrast_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= lcd_contrast_pkg::resp_okay;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_value;
      rresp_q <= rd_hit ? lcd_contrast_pkg::resp_okay : lcd_contrast_pkg::resp_slverr;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= lcd_contrast_pkg::contrast_control_reset;
      cmp_q <= lcd_contrast_pkg::compare_level_reset;
      mask_q <= lcd_contrast_pkg::irq_reset;
      pend_q <= lcd_contrast_pkg::irq_reset;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      cmp_q <= cmp_d;
      mask_q <= mask_d;
      pend_q <= pend_d;
      irq_q <= |(pend_d & mask_d);
    end
  end

  assign cfg.prescale_select = ctrl_q[lcd_contrast_pkg::prescale_select_lsb +: 2];
  assign cfg.pulse_level_select = ctrl_q[lcd_contrast_pkg::pulse_level_select_bit];
  assign cfg.contrast_run = ctrl_q[lcd_contrast_pkg::contrast_run_bit];
  assign cfg.compare_level = cmp_q;

  contrast_pwm u_pwm (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg.gen)
  );

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign contrast_out = cfg.contrast_out;
  assign irq = irq_q;
endmodule
`default_nettype wire

// File: bench/contrast_filter_model.sv
// behavioural stand-in for the external filter on the contrast output
`timescale 1ns/1ps
`default_nettype none
module contrast_filter_model (
  // clock and pulse input
  input wire logic aclk,
  input wire logic contrast_in,
  // integrator control and level
  input wire logic clear,
  output var int level
);
  // a count of high cycles stands in for the capacitor charge, so duty is exact
  always @(posedge aclk) begin
    if (clear) begin
      level <= 0;
    end else begin
      level <= level + (contrast_in ? 1 : 0);
    end
  end
endmodule
`default_nettype wire

// File: bench/lcd_contrast_props.sv
// assertions on the bus and interrupt ports of the contrast register block
`timescale 1ns/1ps
`default_nettype none
module lcd_contrast_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write response
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  input wire logic irq
);
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  property p_ans; s_ar |=> s_axi_rvalid; endproperty
  a_ans: assert property (p_ans) else $error("read answer late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer moved");
  property p_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_busy: assert property (p_busy) else $error("read taken while busy");
  property p_wide; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
  a_wide: assert property (p_wide) else $error("upper read bits set");
  property p_err; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  property p_resp; s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2; endproperty
  a_resp: assert property (p_resp) else $error("odd read response");
  // irq may only drop on a pending read or a completed write
  property p_fall; $fell(irq) |-> $past(ar_hs) || $rose(s_axi_bvalid); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped alone");
endmodule
bind lcd_contrast_pwm_irq_regs lcd_contrast_props chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the contrast and interrupt registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t got %h want %h", $time, g, e); end end
module tb;
  localparam logic [31:0] base = 32'h0060_0840;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, clr = 0;
  logic awready, wready, bvalid, arready, rvalid, cout, irq;
  logic [1:0] bresp, rresp;
  logic [5:0] ev = 0;
  int fail_count = 0, comparisons = 0, level;
  always #2 aclk = ~aclk;
  lcd_contrast_pwm_irq_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .each_line_evt(ev[0]), .final_line_evt(ev[1]), .frame_done_evt(ev[2]), .fifo_empty_evt(ev[3]),
    .fifo_overrun_evt(ev[4]), .dma_fault_evt(ev[5]), .contrast_out(cout), .irq(irq));
  contrast_filter_model filt_u (.aclk(aclk), .contrast_in(cout), .clear(clr), .level(level));
  // readies are combinational from flops, so they are sampled settled at the falling edge
  task automatic wr(input int n, input logic [31:0] d);
    logic ta, tw, aw = 0, w = 0;
    @(posedge aclk);
    awaddr <= base + 32'(4 * n);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      aw = aw | ta;
      w = w | tw;
    end
    do @(negedge aclk); while (!bvalid);
    `CHK(bresp, (n > 6) ? 2'h2 : 2'h0)
    // ready comes one cycle late on purpose, so the response must stand while it waits
    @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input int n, input logic [31:0] e);
    @(posedge aclk);
    araddr <= base + 32'(4 * n);
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    `CHK(rresp, (n > 6) ? 2'h2 : 2'h0)
    `CHK(rdata, e)
    @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge aclk);
    ev <= 6'(1 << k);
    @(posedge aclk);
    ev <= 6'h0;
  endtask
  task automatic measure(input int c);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (c) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic t_reset;
    for (int n = 0; n < 8; n++) rd(n, 32'h0000_0000);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_regs;
    wr(1, 32'hffff_ffff);
    rd(1, 32'h0000_00ff);
    wr(0, 32'hffff_fff3);
    rd(0, 32'h0000_0003);
    wr(4, 32'hffff_ffff);
    rd(4, 32'h0000_0000);
    wr(7, 32'h0000_0000);
  endtask
  task automatic t_mask;
    wr(2, 32'hffff_ffff);
    rd(4, 32'h0000_0077);
    wr(3, 32'h0000_0011);
    rd(4, 32'h0000_0066);
    wr(2, 32'h0000_0000);
    rd(4, 32'h0000_0066);
  endtask
  // mask is 0x66 here, so events 0 and 3 stay quiet on irq
  task automatic t_events;
    logic [6:0] b;
    for (int k = 0; k < 6; k++) begin
      b = 7'(1 << (k > 2 ? k + 1 : k));
      pulse(k);
      @(negedge aclk);
      `CHK(irq, |(b & 7'h66))
      rd(5, 32'(b));
      @(negedge aclk);
      `CHK(irq, 1'b0)
      pulse(k);
      wr(6, 32'(~b));
      rd(5, 32'(b));
      pulse(k);
      wr(6, 32'(b));
      rd(5, 32'h0000_0000);
    end
    // an event in the same cycle as a clearing read must survive the read
    fork
      pulse(0);
      rd(5, 32'h0000_0000);
    join
    rd(5, 32'h0000_0001);
  endtask
  // one full period per window, after one period to let the prescaler settle
  task automatic t_pwm;
    wr(1, 32'h0000_0040);
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) begin
        wr(0, 32'(8 + 4 * p + s));
        repeat (256 << s) @(posedge aclk);
        measure(256 << s);
        `CHK(level, (p ? 64 : 192) << s)
      end
    end
    wr(0, 32'h0000_0004);
    measure(64);
    `CHK(level % 64, 0)
    wr(1, 32'h0000_0000);
    wr(0, 32'h0000_000c);
    measure(256);
    `CHK(level, 0)
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_regs;
    t_mask;
    t_events;
    t_pwm;
    results;
  end
  initial begin
    #200000;
    fail_count++;
    results;
  end
endmodule
`default_nettype wire
